/* rtl/ush_pkg.sv */
// Constants shared by the service framer and its testbench.
// Assumes a byte-wide stream toward and from the device's fixed UDP service port.
package ush_pkg;
    // ------------------------------------------------------------------
    // Fixed service port and header layout
    // ------------------------------------------------------------------
    localparam logic [15:0] SVC_PORT = 16'h0bee;
    localparam logic [15:0] CHECK_XOR = 16'h4242;
    localparam logic [3:0] HDR_LEN = 4'h8;
    localparam logic [3:0] OFS_KEY_HI = 4'h0;
    localparam logic [3:0] OFS_KEY_LO = 4'h1;
    localparam logic [3:0] OFS_CHK_HI = 4'h2;
    localparam logic [3:0] OFS_CHK_LO = 4'h3;
    localparam logic [3:0] OFS_SEQ_ID = 4'h4;
    localparam logic [3:0] OFS_ENC_PAD = 4'h5;
    localparam logic [3:0] OFS_CMD = 4'h6;
    localparam logic [3:0] OFS_OPT = 4'h7;
    localparam logic [3:0] OFS_FRAME_ID = 4'h8;
    localparam int OPT_ACK_BIT = 1;
    // ------------------------------------------------------------------
    // Service command identifiers
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_DATA = 8'h00;
    localparam logic [7:0] CMD_REMOTE = 8'h02;
    localparam logic [7:0] CMD_MEMORY = 8'h03;
    localparam logic [7:0] CMD_IO_SAMPLE = 8'h04;
    localparam logic [7:0] CMD_DATA_ACK = 8'h80;
    localparam logic [7:0] CMD_REMOTE_RSP = 8'h82;
    localparam logic [7:0] CMD_MEMORY_RSP = 8'h83;
    // ------------------------------------------------------------------
    // Local host frame types
    // ------------------------------------------------------------------
    localparam logic [7:0] API_TX_REQ = 8'h00;
    localparam logic [7:0] API_REMOTE = 8'h07;
    localparam logic [7:0] API_LEG_TX = 8'h10;
    localparam logic [7:0] API_EXPLICIT = 8'h11;
    localparam logic [7:0] API_LEG_REMOTE = 8'h17;
    localparam logic [7:0] API_NATIVE_TX = 8'h20;
    localparam logic [7:0] API_RX_PKT = 8'h80;
    localparam logic [7:0] FW_CLUSTER = 8'h23;
    localparam logic [7:0] ASSOC_OK = 8'h00;
    localparam logic [7:0] ASSOC_PORT_CLASH = 8'h2a;
    // ------------------------------------------------------------------
    // Controller registers (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_KEY = 5'h04;
    localparam logic [4:0] REG_PORTS = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0c;
    localparam logic [4:0] REG_RXINFO = 5'h10;
    localparam int CTRL_TYPE_LSB = 0;
    localparam int CTRL_ACK_BIT = 8;
    localparam int CTRL_GO_BIT = 9;
    localparam int CTRL_CLR_BIT = 10;
    localparam int CTRL_CLUSTER_LSB = 16;
    localparam int CTRL_FID_LSB = 24;
    localparam logic [15:0] KEY_RESET = 16'h0000;
    localparam logic [15:0] PORT_RESET = 16'h2616;
endpackage

/* rtl/ush_stream_if.sv */
// Byte stream with valid and ready between the framer and its buffer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ush_stream_if #(parameter int W = 9);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface // ush_stream_if

/* rtl/ush_buf2.sv */
// Two-entry buffer on the received payload path.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ush_buf2 #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Streams
    ush_stream_if.snk in_s,
    ush_stream_if.src out_s
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wp;
        logic rp;
        logic [1:0] cnt;
    } ush_buf_t;

    ush_buf_t s_q, s_d;
    logic push, pop;

    assign in_s.ready = (s_q.cnt != 2'd2);
    assign out_s.valid = (s_q.cnt != 2'd0);
    assign out_s.data = s_q.mem[s_q.rp];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = in_s.data;
            s_d.wp = ~s_q.wp;
        end
        if (pop) begin
            s_d.rp = ~s_q.rp;
        end
        s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // ush_buf2

/* rtl/ush_framer.sv */
// Host-side framer for the device's fixed-port UDP service.
// Assumes a byte stream toward the device and one back, both on the same clock.
// Summary of operation
// - Sender puts a free two-byte key word at offset 0.
// - Check word at offset 2 equals key word xor 0x4242.
// - Sequence id and padding bytes at offsets 4 and 5 are zero.
// - Requests: 0x00 data, 0x02 remote, 0x03 memory, 0x04 I/O sample; this framer sends only 0x00 and 0x02.
// - Replies: 0x80 data ack, 0x82 remote response, 0x83 memory response.
// - Options bit 1 asks the receiver for an acknowledgement.
// - Options bit 0 and bits 2 to 7 are sent as zero.
// - Every command and response starts with the eight-byte header.
// - Firmware update uses frame type 0x11 with cluster 0x23.
// - Native type 0x20 is preferred for new data traffic.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module ush_framer
    import ush_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Outgoing packet bytes toward the device
    output logic [7:0] tx_byte,
    output logic tx_last,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [15:0] udp_src_port,
    output logic [15:0] udp_dst_port,
    // Incoming packet bytes from the device
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    input wire logic rx_valid,
    output logic rx_ready,
    // Payload to send, from the user
    input wire logic [7:0] src_data,
    input wire logic src_last,
    input wire logic src_valid,
    output logic src_ready,
    // Received payload, to the user
    output logic [7:0] pay_data,
    output logic pay_last,
    output logic pay_valid,
    input wire logic pay_ready
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_HDR = 4'b0010,
        TX_FID = 4'b0100,
        TX_BODY = 4'b1000
    } ush_tx_t;

    typedef struct packed {
        ush_tx_t st;
        logic [3:0] tx_cnt;
        logic [7:0] tx_byte;
        logic tx_last;
        logic tx_valid;
        logic tx_is_ack;
        logic [7:0] tx_cmd;
        logic [7:0] tx_opt;
        logic [7:0] api_type;
        logic ack_req;
        logic [7:0] cluster;
        logic [7:0] frame_id;
        logic [15:0] key;
        logic [15:0] svc_port;
        logic [15:0] dst_port;
        logic go_pend;
        logic ack_pend;
        logic refused;
        logic [3:0] rx_cnt;
        logic [15:0] rx_key;
        logic [7:0] rx_chk_hi;
        logic rx_bad;
        logic rx_ok;
        logic [7:0] rx_cmd;
        logic [7:0] rx_opt;
        logic [7:0] rx_fid;
        logic fid_mismatch;
        logic [7:0] bad_cnt;
        logic [31:0] rdata;
    } ush_state_t;

    ush_state_t s_q, s_d;
    ush_stream_if #(.W(9)) buf_in ();
    ush_stream_if #(.W(9)) buf_out ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] hdr_byte(input logic [3:0] idx, input logic [15:0] key,
                                            input logic [7:0] cmd, input logic [7:0] opt);
        logic [15:0] chk;
        chk = key ^ CHECK_XOR;
        unique case (idx)
            OFS_KEY_HI: hdr_byte = key[15:8];
            OFS_KEY_LO: hdr_byte = key[7:0];
            OFS_CHK_HI: hdr_byte = chk[15:8];
            OFS_CHK_LO: hdr_byte = chk[7:0];
            OFS_CMD: hdr_byte = cmd;
            OFS_OPT: hdr_byte = opt;
            default: hdr_byte = 8'h00;
        endcase
    endfunction

    // Returns {accepted, service command} for a local host frame type
    function automatic logic [8:0] api_to_cmd(input logic [7:0] t, input logic [7:0] cluster);
        unique case (t)
            API_TX_REQ, API_NATIVE_TX, API_LEG_TX: api_to_cmd = {1'b1, CMD_DATA};
            API_REMOTE, API_LEG_REMOTE: api_to_cmd = {1'b1, CMD_REMOTE};
            API_EXPLICIT: api_to_cmd = {cluster == FW_CLUSTER, CMD_DATA};
            default: api_to_cmd = {1'b0, CMD_DATA};
        endcase
    endfunction

    logic clash, slot_free, rx_take, fwd, busy;
    logic [8:0] map, go_map;

    // Either port sitting on the service port blocks all traffic
    assign clash = (s_q.svc_port == SVC_PORT) || (s_q.dst_port == SVC_PORT);
    assign slot_free = !s_q.tx_valid || tx_ready;
    assign busy = s_q.go_pend || (s_q.st != TX_IDLE);
    assign map = api_to_cmd(s_q.api_type, s_q.cluster);
    assign go_map = api_to_cmd(reg_wdata[CTRL_TYPE_LSB +: 8], reg_wdata[CTRL_CLUSTER_LSB +: 8]);
    // Payload is forwarded only after a good data header
    assign fwd = (s_q.rx_cnt >= HDR_LEN) && s_q.rx_ok && (s_q.rx_cmd == CMD_DATA);
    assign rx_ready = fwd ? buf_in.ready : 1'b1;
    assign rx_take = rx_valid && rx_ready;
    assign src_ready = (s_q.st == TX_BODY) && slot_free;

    assign buf_in.valid = rx_valid && fwd;
    assign buf_in.data = {rx_last, rx_byte};
    assign buf_out.ready = pay_ready;
    assign pay_data = buf_out.data[7:0];
    assign pay_last = buf_out.data[8];
    assign pay_valid = buf_out.valid;

    assign tx_byte = s_q.tx_byte;
    assign tx_last = s_q.tx_last;
    assign tx_valid = s_q.tx_valid;
    assign udp_src_port = SVC_PORT;
    assign udp_dst_port = SVC_PORT;
    assign reg_rdata = s_q.rdata;

    always_comb begin
        logic ack_set, ack_take, fid_set;
        ack_set = 1'b0;
        ack_take = 1'b0;
        fid_set = 1'b0;
        s_d = s_q;
        if (slot_free) begin
            s_d.tx_valid = 1'b0;
            s_d.tx_last = 1'b0;
        end
        // ------------------------------------------------------------------
        // Transmit sequencer
        // ------------------------------------------------------------------
        unique case (s_q.st)
            TX_IDLE: begin
                if (slot_free && !clash) begin
                    if (s_q.ack_pend) begin
                        ack_take = 1'b1;
                        s_d.tx_is_ack = 1'b1;
                        s_d.tx_cmd = CMD_DATA_ACK;
                        s_d.tx_opt = 8'h00;
                        s_d.tx_cnt = 4'h0;
                        s_d.st = TX_HDR;
                    end else if (s_q.go_pend) begin
                        s_d.go_pend = 1'b0;
                        s_d.tx_is_ack = 1'b0;
                        s_d.tx_cmd = map[7:0];
                        // Only the ack request bit may be set
                        s_d.tx_opt = 8'h00;
                        s_d.tx_opt[OPT_ACK_BIT] = s_q.ack_req && (map[7:0] == CMD_DATA);
                        s_d.tx_cnt = 4'h0;
                        s_d.st = TX_HDR;
                    end
                end
            end
            TX_HDR: begin
                if (slot_free) begin
                    s_d.tx_byte = hdr_byte(s_q.tx_cnt, s_q.key, s_q.tx_cmd, s_q.tx_opt);
                    s_d.tx_valid = 1'b1;
                    s_d.tx_cnt = s_q.tx_cnt + 4'h1;
                    if (s_q.tx_cnt == OFS_OPT) begin
                        if (s_q.tx_is_ack) begin
                            s_d.tx_last = 1'b1;
                            s_d.st = TX_IDLE;
                        end else if (s_q.tx_cmd == CMD_REMOTE) begin
                            s_d.st = TX_FID;
                        end else begin
                            s_d.st = TX_BODY;
                        end
                    end
                end
            end
            TX_FID: begin
                if (slot_free) begin
                    s_d.tx_byte = s_q.frame_id;
                    s_d.tx_valid = 1'b1;
                    s_d.st = TX_BODY;
                end
            end
            TX_BODY: begin
                // Sent once only; no copy is kept for a retry
                if (slot_free && src_valid) begin
                    s_d.tx_byte = src_data;
                    s_d.tx_valid = 1'b1;
                    s_d.tx_last = src_last;
                    if (src_last) begin
                        s_d.st = TX_IDLE;
                    end
                end
            end
            default: s_d.st = TX_IDLE;
        endcase
        // ------------------------------------------------------------------
        // Receive header parser
        // ------------------------------------------------------------------
        if (rx_take) begin
            unique case (s_q.rx_cnt)
                OFS_KEY_HI: s_d.rx_key[15:8] = rx_byte;
                OFS_KEY_LO: s_d.rx_key[7:0] = rx_byte;
                OFS_CHK_HI: s_d.rx_chk_hi = rx_byte;
                OFS_CHK_LO: s_d.rx_bad = {s_q.rx_chk_hi, rx_byte} != (s_q.rx_key ^ CHECK_XOR);
                OFS_CMD: s_d.rx_cmd = rx_byte;
                OFS_OPT: begin
                    s_d.rx_opt = rx_byte;
                    s_d.rx_ok = !s_q.rx_bad && !clash;
                    if (s_q.rx_bad || clash) begin
                        s_d.bad_cnt = s_q.bad_cnt + 8'h01;
                    end else if (s_q.rx_cmd == CMD_DATA && rx_byte[OPT_ACK_BIT]) begin
                        ack_set = 1'b1;
                    end
                end
                OFS_FRAME_ID: begin
                    if (s_q.rx_ok && (s_q.rx_cmd == CMD_REMOTE_RSP || s_q.rx_cmd == CMD_MEMORY_RSP)) begin
                        s_d.rx_fid = rx_byte;
                        fid_set = rx_byte != s_q.frame_id;
                        s_d.fid_mismatch = s_q.fid_mismatch || fid_set;
                    end
                end
                default: ;
            endcase
            if (s_q.rx_cnt <= HDR_LEN) begin
                s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            end
            if (rx_last) begin
                s_d.rx_cnt = 4'h0;
                // A packet shorter than the header is never acted on
                if (s_q.rx_cnt < OFS_OPT) begin
                    s_d.bad_cnt = s_q.bad_cnt + 8'h01;
                end
            end
        end
        // ------------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------------
        s_d.rdata = 32'h0000_0000;
        if (reg_read) begin
            unique case (reg_addr)
                REG_CTRL: s_d.rdata = {s_q.frame_id, s_q.cluster, 6'h00, s_q.go_pend, s_q.ack_req,
                                       s_q.api_type};
                REG_KEY: s_d.rdata = {16'h0000, s_q.key};
                REG_PORTS: s_d.rdata = {s_q.dst_port, s_q.svc_port};
                REG_STATUS: s_d.rdata = {s_q.bad_cnt, (clash ? ASSOC_PORT_CLASH : ASSOC_OK), 5'h00,
                                         s_q.fid_mismatch, s_q.refused, busy, 8'h00};
                REG_RXINFO: s_d.rdata = {(s_q.rx_cmd == CMD_DATA ? API_RX_PKT : s_q.rx_cmd),
                                         s_q.rx_fid, s_q.rx_opt, s_q.rx_cmd};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_write) begin
            unique case (reg_addr)
                REG_CTRL: begin
                    s_d.api_type = reg_wdata[CTRL_TYPE_LSB +: 8];
                    s_d.ack_req = reg_wdata[CTRL_ACK_BIT];
                    s_d.cluster = reg_wdata[CTRL_CLUSTER_LSB +: 8];
                    s_d.frame_id = reg_wdata[CTRL_FID_LSB +: 8];
                    if (reg_wdata[CTRL_CLR_BIT]) begin
                        s_d.refused = 1'b0;
                        s_d.fid_mismatch = fid_set; // Sticky flag: a fresh mismatch wins
                    end
                    if (reg_wdata[CTRL_GO_BIT]) begin
                        if (busy || clash || !go_map[8]) begin
                            s_d.refused = 1'b1;
                        end else begin
                            s_d.go_pend = 1'b1;
                        end
                    end
                end
                REG_KEY: s_d.key = reg_wdata[15:0];
                REG_PORTS: begin
                    s_d.svc_port = reg_wdata[15:0];
                    s_d.dst_port = reg_wdata[31:16];
                end
                default: ;
            endcase
        end
        // A request arriving as the pending one is taken is kept
        s_d.ack_pend = (s_q.ack_pend && !ack_take) || ack_set;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
            s_q.st <= TX_IDLE;
            s_q.key <= KEY_RESET;
            s_q.svc_port <= PORT_RESET;
            s_q.dst_port <= PORT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Received payload buffer
    // ------------------------------------------------------------------
    ush_buf2 #(.W(9)) u_buf (
        .clock(clock),
        .reset(reset),
        .in_s(buf_in),
        .out_s(buf_out)
    );
endmodule // ush_framer

/* verif/ush_framer_monitor.sv */
// Port checker for the service framer, bound into every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ush_framer_chk (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Outgoing packet bytes
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [15:0] udp_src_port,
    input wire logic [15:0] udp_dst_port,
    // Received payload
    input wire logic [7:0] pay_data,
    input wire logic pay_valid,
    input wire logic pay_ready
);
    typedef struct packed {logic [3:0] idx; logic [7:0] khi; logic [7:0] klo; logic [7:0] cmd;} ush_chk_t;
    ush_chk_t st_q, st_d;
    logic acc;
    assign acc = tx_valid && tx_ready;
    // Position saturates so a runaway packet never aliases the header
    always_comb begin
        st_d = st_q;
        if (acc) begin
            st_d.idx = tx_last ? 4'h0 : st_q.idx + {3'h0, st_q.idx != 4'hf};
            if (st_q.idx == 4'h0)
                st_d.khi = tx_byte;
            if (st_q.idx == 4'h1)
                st_d.klo = tx_byte;
            if (st_q.idx == 4'h6)
                st_d.cmd = tx_byte;
        end
    end
    always_ff @(posedge clock) begin
        if (reset)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    // ----
    // Header, port and handshake checks
    // ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_take(int k);
        acc && st_q.idx == k;
    endsequence
    a_fixed_port: assert property (udp_src_port == 16'h0bee && udp_dst_port == 16'h0bee)
        else $error("service port moved");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable({tx_last, tx_byte}))
        else $error("tx byte dropped");
    a_check_hi: assert property (s_take(2) |-> tx_byte == (st_q.khi ^ 8'h42))
        else $error("check hi wrong");
    a_check_lo: assert property (s_take(3) |-> tx_byte == (st_q.klo ^ 8'h42))
        else $error("check lo wrong");
    a_rsvd_zero: assert property (acc && (st_q.idx == 4'h4 || st_q.idx == 4'h5) |-> tx_byte == 8'h00)
        else $error("reserved byte set");
    a_cmd_code: assert property (s_take(6) |-> tx_byte inside {8'h00, 8'h02, 8'h80})
        else $error("bad command byte");
    a_opt_clean: assert property (s_take(7) |-> tx_byte[0] == 1'b0 && tx_byte[7:2] == 6'h00)
        else $error("option bits set");
    a_opt_ack: assert property (s_take(7) && st_q.cmd != 8'h00 |-> tx_byte[1] == 1'b0)
        else $error("ack on non data");
    a_ack_short: assert property (s_take(7) && st_q.cmd == 8'h80 |-> tx_last && tx_byte == 8'h00)
        else $error("bad ack packet");
    a_full_header: assert property (acc && tx_last |-> st_q.idx >= 4'h7)
        else $error("short packet");
    a_pay_hold: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay_data))
        else $error("payload lost");
endmodule // ush_framer_chk

bind ush_framer ush_framer_chk chk_u (.clock(clock), .reset(reset), .tx_byte(tx_byte), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .udp_src_port(udp_src_port), .udp_dst_port(udp_dst_port),
    .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready));

/* verif/ush_dev_model.sv */
// Device model: takes framer packets and sends service packets back.
// Assumes send is called right after a rising clock edge.
`timescale 1ns/1ps
module ush_dev_model (
    // Clock and pacing
    input wire logic clock,
    input wire logic slow,
    // Bytes from the framer
    input wire logic [7:0] tx_byte,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    // Bytes toward the framer
    output logic [7:0] rx_byte,
    output logic rx_last,
    output logic rx_valid,
    input wire logic rx_ready
);
    logic [8:0] got[$];
    initial {tx_ready, rx_byte, rx_last, rx_valid} = '0;
    // Packets are taken once only; unacknowledged ones are never resent
    always @(posedge clock) begin
        if (tx_valid && tx_ready)
            got.push_back({tx_last, tx_byte});
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    task automatic send(input logic [15:0] key, input logic [7:0] cmd, input logic [7:0] opt,
            input logic bad, input logic [7:0] pay[$]);
        logic [15:0] chk;
        logic [7:0] b[$];
        chk = key ^ 16'h4242 ^ {15'h0, bad};
        b = {key[15:8], key[7:0], chk[15:8], chk[7:0], 8'h00, 8'h00, cmd, opt};
        b = {b, pay};
        foreach (b[i]) begin
            rx_byte <= b[i];
            rx_last <= (i == b.size() - 1);
            rx_valid <= 1'b1;
            do @(negedge clock); while (rx_ready !== 1'b1);
            @(posedge clock);
        end
        // Released line shows the inverse so a stale byte cannot pass
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_byte <= ~b[b.size() - 1];
    endtask
endmodule // ush_dev_model

/* verif/test_udp_service_header_framer.sv */
// Bench for the service framer against the device model.
// Assumes the model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_udp_service_header_framer import ush_pkg::*; ;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] src_data = 8'h00;
    logic src_last = 1'b0;
    logic src_valid = 1'b0;
    logic pay_ready = 1'b0;
    logic pay_go = 1'b0;
    logic slow = 1'b0;
    logic [31:0] reg_rdata, st;
    logic [7:0] tx_byte, rx_byte, pay_data;
    logic tx_last, tx_valid, tx_ready, rx_last, rx_valid, rx_ready, src_ready, pay_last, pay_valid;
    logic [15:0] udp_src_port, udp_dst_port;
    logic [8:0] pq[$];
    int err_total = 0;
    int n_checks = 0;
    always #10 clock = ~clock;
    ush_framer dut_u (.*);
    ush_dev_model dev_u (.*);
    always @(posedge clock) begin
        pay_ready <= pay_go & ~pay_ready;
        if (pay_valid && pay_ready)
            pq.push_back({pay_last, pay_data});
    end
    // ----
    // Bus and check helpers
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic t_regs;
        rd(REG_PORTS, st);
        check(st, 32'h2616_2616);
        wr(5'h14, 32'h5555_5555);
        rd(5'h14, st);
        check(st, 32'h0);
        wr(REG_KEY, 32'h0000_1234);
        rd(REG_KEY, st);
        check(st, 32'h0000_1234);
        check({udp_src_port, udp_dst_port}, 32'h0bee_0bee);
    endtask
    task automatic t_send(input logic [7:0] ty, input logic [7:0] cmd);
        logic [7:0] e[$];
        e = {8'h12, 8'h34, 8'h50, 8'h76, 8'h00, 8'h00, cmd, (cmd == 8'h00) ? 8'h02 : 8'h00};
        if (cmd == CMD_REMOTE)
            e.push_back(8'h5a);
        e.push_back(8'ha5);
        dev_u.got.delete();
        wr(REG_CTRL, {8'h5a, 8'h23, 8'h03, ty});
        src_data <= 8'ha5;
        src_last <= 1'b1;
        src_valid <= 1'b1;
        do @(negedge clock); while (src_ready !== 1'b1);
        @(posedge clock);
        src_valid <= 1'b0;
        repeat (200) if (dev_u.got.size() < e.size()) @(posedge clock);
        check(dev_u.got.size(), e.size());
        foreach (e[i]) check(dev_u.got[i], {i == e.size() - 1, e[i]});
    endtask
    task automatic t_refuse(input logic [7:0] ty, input logic [7:0] cl);
        dev_u.got.delete();
        wr(REG_CTRL, {8'h5a, cl, 8'h02, ty});
        repeat (12) @(posedge clock);
        rd(REG_STATUS, st);
        check(st[9], 1'b1);
        check(dev_u.got.size(), 0);
        wr(REG_CTRL, 32'h0000_0400);
    endtask
    task automatic t_drop(input logic [31:0] ports, input logic bad, input logic [15:0] cnt_ai);
        dev_u.got.delete();
        wr(REG_PORTS, ports);
        if (cnt_ai[7:0] != 8'h00)
            wr(REG_CTRL, 32'h0000_0300);
        dev_u.send(16'h3333, CMD_DATA, 8'h02, bad, {8'h44});
        repeat (20) @(posedge clock);
        rd(REG_STATUS, st);
        check(st[31:16], cnt_ai);
        check(dev_u.got.size() + pq.size(), 0);
        wr(REG_PORTS, 32'h2616_2616);
        wr(REG_CTRL, 32'h0000_0400);
    endtask
    task automatic t_rx;
        dev_u.got.delete();
        fork
            dev_u.send(16'h0f0f, CMD_DATA, 8'h02, 1'b0, {8'h11, 8'h22, 8'h33});
            begin
                repeat (14) @(negedge clock);
                check(rx_ready, 1'b0);
                pay_go <= 1'b1;
            end
        join
        repeat (40) @(posedge clock);
        check({pq[0], pq[1], pq[2]}, {9'h011, 9'h022, 9'h133});
        check({dev_u.got[0], dev_u.got[2]}, {9'h012, 9'h050});
        check({dev_u.got[6], dev_u.got[7]}, {9'h080, 9'h100});
        rd(REG_RXINFO, st);
        check({st[31:24], st[7:0]}, {API_RX_PKT, CMD_DATA});
    endtask
    task automatic t_rsp(input logic [7:0] fid, input logic mis);
        dev_u.send(16'h2222, CMD_REMOTE_RSP, 8'h00, 1'b0, {fid, 8'h49});
        repeat (2) @(posedge clock);
        rd(REG_RXINFO, st);
        check(st[23:0], {fid, 8'h00, CMD_REMOTE_RSP});
        rd(REG_STATUS, st);
        check(st[10], mis);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_regs;
        t_send(API_TX_REQ, CMD_DATA);
        t_send(API_LEG_TX, CMD_DATA);
        slow <= 1'b1;
        t_send(API_NATIVE_TX, CMD_DATA);
        t_send(API_REMOTE, CMD_REMOTE);
        t_send(API_LEG_REMOTE, CMD_REMOTE);
        t_send(API_EXPLICIT, CMD_DATA);
        t_refuse(API_EXPLICIT, 8'h22);
        t_refuse(8'h55, FW_CLUSTER);
        t_drop(32'h2616_0bee, 1'b0, {8'h01, ASSOC_PORT_CLASH});
        t_drop(32'h0bee_2616, 1'b0, {8'h02, ASSOC_PORT_CLASH});
        t_drop(32'h2616_2616, 1'b1, {8'h03, ASSOC_OK});
        t_rx;
        wr(REG_CTRL, 32'h5a00_0007);
        t_rsp(8'h5a, 1'b0);
        t_rsp(8'h66, 1'b1);
        wrap_up;
    end
    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        wrap_up;
    end
endmodule // test_udp_service_header_framer
